// ---- inc/acmc_pkg.sv ----
// Constants and types for the conversion-mode control of a 16-channel analog input board.
// Assumes a 200 MHz core clock; straps and switches arrive as raw pins.
package acmc_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned AUTO_DELAY_MS = 50;
  localparam int unsigned AUTO_DELAY_CYC = AUTO_DELAY_MS * 1000 * CLK_MHZ;
  localparam int DELAY_W = 24;

  // ==========================================================
  // Locations and fields
  localparam logic [1:0] OFS_START_WIDE = 2'h0;
  localparam logic [1:0] OFS_START_NARROW = 2'h1;
  localparam logic [1:0] OFS_GAIN_CHAN = 2'h2;
  localparam logic [1:0] OFS_UNUSED = 2'h3;
  localparam int GAIN_MSB = 5;
  localparam int GAIN_LSB = 4;
  localparam int CHAN_MSB = 3;
  localparam int CHAN_LSB = 0;
  localparam int CHANNELS = 16;

  // ==========================================================
  // Gain codes and reset values
  localparam logic [1:0] GAIN_10V = 2'h0;
  localparam logic [1:0] GAIN_5V = 2'h1;
  localparam logic [1:0] GAIN_2V5 = 2'h2;
  localparam logic [1:0] GAIN_1V25 = 2'h3;
  localparam logic [1:0] GAIN_RST = GAIN_10V;
  localparam logic [3:0] CHAN_RST = 4'h0;
  localparam logic [11:0] RESULT_RST = 12'h000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CONV = 2'b11
  } acmc_state_e;

  typedef struct packed {
    logic auto_convert_strap;
    logic resolution_strap;
    logic fixed_gain;
    logic gain_switch_bit_a;
    logic gain_switch_bit_b;
  } acmc_straps_s;

  typedef struct packed {
    logic wide;
    logic [3:0] channel;
    logic [1:0] gain;
  } acmc_req_s;
endpackage

// ---- rtl/acmc_ctrl.sv ----
// Conversion-mode control: cable register decode, strap handling and converter launch.
// Assumes a converter on core_clk that answers conv_start with a conv_done pulse.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
module acmc_ctrl #(
  parameter int unsigned AUTO_DELAY_CYCLES = acmc_pkg::AUTO_DELAY_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [1:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire acmc_pkg::acmc_straps_s strap_pins,
  input wire logic conv_done,
  input wire logic [11:0] conv_result,
  output logic conv_start,
  output acmc_pkg::acmc_req_s conv_req,
  output logic busy
);
  import acmc_pkg::*;

  // ==========================================================
  // Strap synchronisers
  acmc_straps_s strap_meta;
  acmc_straps_s straps;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strap_meta <= '0;
      straps <= '0;
    end else begin
      strap_meta <= strap_pins;
      straps <= strap_meta;
    end
  end

  // ==========================================================
  // Gain selection
  function automatic logic [1:0] eff_gain(input acmc_straps_s s, input logic [CHANNELS-1:0][1:0] tab,
                                          input logic [3:0] ch);
    if (s.fixed_gain) begin
      eff_gain = {s.gain_switch_bit_a, s.gain_switch_bit_b};
    end else begin
      eff_gain = tab[ch];
    end
  endfunction

  // ==========================================================
  // Control state
  acmc_state_e state, next_state;
  logic [DELAY_W-1:0] cnt, next_cnt;
  logic [CHANNELS-1:0][1:0] gain_tab, next_gain_tab;
  logic [3:0] sel_chan, next_sel_chan;
  logic [11:0] result, next_result;
  acmc_req_s next_req;
  logic next_start;
  logic next_busy;
  logic [7:0] next_rdata;
  logic sgc_wr;
  logic [3:0] wr_chan;
  logic launch;
  logic launch_wide;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_gain_tab = gain_tab;
    next_sel_chan = sel_chan;
    next_result = result;
    next_req = conv_req;
    next_start = 1'b0;
    next_rdata = 8'h00;
    launch = 1'b0;
    launch_wide = 1'b0;
    sgc_wr = bus_wr && (bus_addr == OFS_GAIN_CHAN);
    wr_chan = bus_wdata[CHAN_MSB:CHAN_LSB];
    if (sgc_wr) begin
      next_gain_tab[wr_chan] = bus_wdata[GAIN_MSB:GAIN_LSB];
      next_sel_chan = wr_chan;
    end
    // Low byte carries the last four bits left-justified; narrow results read as zeros there
    if (bus_rd && bus_addr == OFS_START_WIDE) begin
      next_rdata = result[11:4];
    end else if (bus_rd && bus_addr == OFS_START_NARROW) begin
      next_rdata = {result[3:0], 4'h0};
    end else begin
      next_rdata = 8'h00;
    end
    case (state)
      ST_IDLE: begin
        if (sgc_wr && straps.auto_convert_strap) begin
          next_state = ST_WAIT;
          next_cnt = DELAY_W'(AUTO_DELAY_CYCLES);
        end else if (bus_wr && bus_addr == OFS_START_WIDE) begin
          launch = 1'b1;
          launch_wide = straps.resolution_strap;
        end else if (bus_wr && bus_addr == OFS_START_NARROW) begin
          launch = 1'b1;
        end
      end
      ST_WAIT: begin
        // A fresh gain/channel write restarts the wait so the latest channel is sampled
        if (sgc_wr) begin
          next_cnt = DELAY_W'(AUTO_DELAY_CYCLES);
        end else if (cnt <= DELAY_W'(1)) begin
          launch = 1'b1;
          launch_wide = straps.resolution_strap;
        end else begin
          next_cnt = cnt - DELAY_W'(1);
        end
      end
      ST_CONV: begin
        if (conv_done) begin
          next_result = conv_result;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (launch) begin
      next_start = 1'b1;
      next_state = ST_CONV;
      next_req.wide = launch_wide;
      next_req.channel = next_sel_chan;
      next_req.gain = eff_gain(straps, next_gain_tab, next_sel_chan);
    end
    // Taken from the next state so busy rises together with conv_start, or on entering ST_WAIT after an auto write
    next_busy = (next_state != ST_IDLE);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      cnt <= '0;
      gain_tab <= {CHANNELS{GAIN_RST}};
      sel_chan <= CHAN_RST;
      result <= RESULT_RST;
      conv_req <= '0;
      conv_start <= 1'b0;
      bus_rdata <= 8'h00;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      gain_tab <= next_gain_tab;
      sel_chan <= next_sel_chan;
      result <= next_result;
      conv_req <= next_req;
      conv_start <= next_start;
      bus_rdata <= next_rdata;
      busy <= next_busy;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_auto_arms_wait: assert property (state == ST_IDLE && sgc_wr && straps.auto_convert_strap
    |=> state == ST_WAIT && cnt == DELAY_W'(AUTO_DELAY_CYCLES))
    else $error("auto write did not arm the launch delay");
  a_wait_no_early: assert property (state == ST_WAIT && cnt > DELAY_W'(1)
    |=> !conv_start)
    else $error("auto conversion started early");
  a_wait_launch: assert property (state == ST_WAIT && cnt == DELAY_W'(1) && !sgc_wr
    |=> conv_start && state == ST_CONV)
    else $error("auto conversion missing at end of delay");
  a_auto_res_strap: assert property (conv_start && $past(state) == ST_WAIT
    |-> conv_req.wide == $past(straps.resolution_strap))
    else $error("auto resolution differs from strap");
  a_narrow_forced: assert property (conv_start && !$past(straps.resolution_strap)
    |-> !conv_req.wide)
    else $error("wide conversion with strap at 8 bits");
  a_manual_start: assert property (state == ST_IDLE && bus_wr && !straps.auto_convert_strap
    && bus_addr != OFS_GAIN_CHAN && bus_addr != OFS_UNUSED
    |=> conv_start ##1 !conv_start)
    else $error("manual start not a single pulse");
  a_narrow_request: assert property (state == ST_IDLE && bus_wr && bus_addr == OFS_START_NARROW
    && !straps.auto_convert_strap |=> !conv_req.wide)
    else $error("narrow request turned wide");
  a_fixed_gain: assert property (conv_start && $past(straps.fixed_gain)
    |-> conv_req.gain == $past({straps.gain_switch_bit_a, straps.gain_switch_bit_b}))
    else $error("fixed gain not applied");
  a_soft_gain: assert property (conv_start && !$past(straps.fixed_gain)
    |-> conv_req.gain == gain_tab[conv_req.channel])
    else $error("software gain not applied");
  a_auto_channel: assert property (state == ST_IDLE && sgc_wr && straps.auto_convert_strap
    |=> sel_chan == $past(wr_chan))
    else $error("auto channel not captured");
  a_read_bytes: assert property (bus_rd && bus_addr == OFS_START_WIDE
    |=> bus_rdata == $past(result[11:4]))
    else $error("high byte read wrong");
  a_read_low: assert property (bus_rd && bus_addr == OFS_START_NARROW
    |=> bus_rdata == {$past(result[3:0]), 4'h0})
    else $error("low byte read wrong");
  a_read_idle: assert property (!bus_rd
    |=> bus_rdata == 8'h00)
    else $error("read data not cleared");
  a_unused_quiet: assert property (state == ST_IDLE && bus_wr && bus_addr == OFS_UNUSED
    |=> !conv_start)
    else $error("unused location started a conversion");
  a_gain_write: assert property (sgc_wr
    |=> gain_tab[$past(wr_chan)] == $past(bus_wdata[GAIN_MSB:GAIN_LSB]))
    else $error("gain code not stored");
  a_wait_restart: assert property (state == ST_WAIT && sgc_wr
    |=> state == ST_WAIT && cnt == DELAY_W'(AUTO_DELAY_CYCLES) && !conv_start)
    else $error("wait not restarted by new channel");
  a_done_stores: assert property (state == ST_CONV && conv_done
    |=> state == ST_IDLE && result == $past(conv_result))
    else $error("result not stored at conversion end");
  a_fixed_low_range: assert property (conv_start && $past(straps.fixed_gain)
    && $past(straps.gain_switch_bit_a) && $past(straps.gain_switch_bit_b) |-> conv_req.gain == GAIN_1V25)
    else $error("fixed on/on not decoded as smallest range");
  a_fixed_half_range: assert property (conv_start && $past(straps.fixed_gain)
    && !$past(straps.gain_switch_bit_a) && $past(straps.gain_switch_bit_b) |-> conv_req.gain == GAIN_5V)
    else $error("fixed off/on not decoded as half range");

  c_auto_launch: cover property (state == ST_WAIT ##1 conv_start);
  c_manual_wide: cover property (conv_start && conv_req.wide);
  c_fixed_gain: cover property (conv_start && $past(straps.fixed_gain));
  c_read_low: cover property (bus_rd && bus_addr == OFS_START_NARROW && result != RESULT_RST);
  c_wait_restart: cover property (state == ST_WAIT && sgc_wr);
endmodule

// ---- testbench/acmc_conv_model.sv ----
// Behavioural converter at the far side of the conversion-mode control.
// Assumes conv_start is a one-cycle pulse on core_clk; slow stretches a conversion.
`timescale 1ns/1ps
module acmc_conv_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic conv_start,
  input wire acmc_pkg::acmc_req_s conv_req,
  input wire logic slow,
  output logic conv_done,
  output logic [11:0] conv_result
);
  import acmc_pkg::*;
  // ==========================================================
  // Conversion timer
  int cnt;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      conv_done <= 1'b0;
      conv_result <= 12'h000;
    end else begin
      conv_done <= 1'b0;
      // Flipped outside conv_done so a stale result never looks fresh
      conv_result <= ~conv_result;
      if (conv_start) begin
        cnt <= slow ? 20 : 3;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
        if (cnt == 1) begin
          conv_done <= 1'b1;
          conv_result <= {conv_req.channel, 2'h2, conv_req.gain, conv_req.wide ? 4'h9 : 4'h0};
        end
      end
    end
  end
endmodule

// ---- testbench/adc_conversion_mode_control_bench.sv ----
// Self-checking bench for the conversion-mode control.
// Assumes the converter model beside it; the auto delay is shortened to 8 cycles.
`timescale 1ns/1ps
module adc_conversion_mode_control_bench;
  import acmc_pkg::*;
  logic core_clk = 0, rst = 1, bus_wr = 0, bus_rd = 0, slow = 0, conv_done, conv_start, busy;
  logic [1:0] bus_addr = 2'h0;
  logic [7:0] bus_wdata = 8'h00, bus_rdata;
  logic [11:0] conv_result;
  logic [3:0] lastch = 4'h0;
  logic [1:0] tbl [16];
  acmc_straps_s strap_pins = '0;
  acmc_req_s conv_req;
  int err_count = 0, checked = 0, cyc = 0;
  always #2.5 core_clk = ~core_clk;
  // The delay counts from the cycle after the write, so an auto start lands one cycle past it
  localparam int AUTO_DLY = 8;
  acmc_ctrl #(.AUTO_DELAY_CYCLES(AUTO_DLY)) DUT (.core_clk(core_clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .strap_pins(strap_pins),
    .conv_done(conv_done), .conv_result(conv_result), .conv_start(conv_start), .conv_req(conv_req), .busy(busy));
  acmc_conv_model partner (.core_clk(core_clk), .rst(rst), .conv_start(conv_start), .conv_req(conv_req),
    .slow(slow), .conv_done(conv_done), .conv_result(conv_result));
  // ==========================================================
  // Checking and closing
  task automatic chk(string what, logic [11:0] got, logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // A hang costs a mismatch; the whole run needs about 400 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  // ==========================================================
  // Bus cycles and one conversion
  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(posedge core_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(logic [1:0] a, logic [7:0] e);
    @(posedge core_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    @(negedge core_clk);
    chk("read data", {4'h0, bus_rdata}, {4'h0, e});
  endtask
  task automatic setp(logic [4:0] s);
    @(posedge core_clk);
    strap_pins <= s;
    repeat (3) @(posedge core_clk);
  endtask
  // The converter model packs channel, a marker, gain and resolution into its result
  function automatic logic [11:0] exp_result(logic [3:0] ch, logic [1:0] g, logic w);
    return {ch, 2'h2, g, w ? 4'h9 : 4'h0};
  endfunction
  task automatic conv(logic [1:0] a, logic [7:0] d, int dly);
    logic w;
    logic [1:0] g;
    logic [11:0] r;
    int n;
    if (a == OFS_GAIN_CHAN) begin
      lastch = d[CHAN_MSB:CHAN_LSB];
      tbl[lastch] = d[GAIN_MSB:GAIN_LSB];
    end
    w = strap_pins.resolution_strap && a != OFS_START_NARROW;
    g = strap_pins.fixed_gain ? {strap_pins.gain_switch_bit_a, strap_pins.gain_switch_bit_b} : tbl[lastch];
    r = exp_result(lastch, g, w);
    wr(a, d);
    if (dly == 0) return;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (!conv_start && n < 60);
    chk("start delay", n[11:0], dly[11:0]);
    chk("request", {5'h00, conv_req}, {5'h00, w, lastch, g});
    while (busy) @(negedge core_clk);
    rd(OFS_START_WIDE, r[11:4]);
    rd(OFS_START_NARROW, {r[3:0], 4'h0});
  endtask
  // ==========================================================
  // Tests
  initial begin
    void'($urandom(4700));
    foreach (tbl[i]) tbl[i] = GAIN_RST;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    setp(5'h08);
    conv(OFS_GAIN_CHAN, 8'he5, 0);
    conv(OFS_START_WIDE, 8'h00, 1);
    conv(OFS_START_NARROW, 8'h00, 1);
    repeat (8) begin
      slow <= 1'($urandom_range(1));
      conv(OFS_GAIN_CHAN, 8'($urandom_range(255)), 0);
      conv(2'($urandom_range(1)), 8'($urandom_range(255)), 1);
    end
    $display("test manual done");
    setp(5'h00);
    conv(OFS_START_WIDE, 8'h00, 1);
    for (int k = 0; k < 4; k++) begin
      setp(5'h0c | 5'(k));
      conv(OFS_START_NARROW, 8'h00, 1);
    end
    $display("test straps done");
    setp(5'h18);
    conv(OFS_GAIN_CHAN, 8'($urandom_range(63)), AUTO_DLY + 1);
    // A second write inside the wait restarts it and names the channel sampled
    conv(OFS_GAIN_CHAN, 8'h21, 0);
    conv(OFS_GAIN_CHAN, 8'h1a, AUTO_DLY + 1);
    setp(5'h10);
    conv(OFS_GAIN_CHAN, 8'h3f, AUTO_DLY + 1);
    $display("test auto done");
    setp(5'h08);
    wr(OFS_UNUSED, 8'hff);
    @(negedge core_clk);
    chk("busy", {11'h000, busy}, 12'h000);
    rd(OFS_UNUSED, 8'h00);
    rd(OFS_GAIN_CHAN, 8'h00);
    $display("test unused done");
    end_sim();
  end
endmodule
